// >>> tssfc_pkg.sv
// constants, field layouts and carriers of the two-speed start-up and fail-safe clock block
package tssfc_pkg;

  // register byte offsets
  localparam logic [7:0] TSSFC_CFG_OFS = 8'h00;
  localparam logic [7:0] TSSFC_OSC_CTRL_OFS = 8'h04;
  localparam logic [7:0] TSSFC_CMD_OFS = 8'h08;
  localparam logic [7:0] TSSFC_FLAG2_OFS = 8'h0C;
  localparam logic [7:0] TSSFC_STATUS_OFS = 8'h10;
  localparam logic [7:0] TSSFC_WDT_CTRL_OFS = 8'h14;
  localparam logic [7:0] TSSFC_WDT_COUNT_OFS = 8'h18;

  // field positions
  localparam int TSSFC_CFG_INTERNAL_EXTERNAL_SWITCHOVER_ENABLE_BIT = 0;
  localparam int TSSFC_CFG_FCM_BIT = 1;
  localparam int TSSFC_CFG_MODE_LSB = 2;
  localparam int TSSFC_READY_BIT = 3;
  localparam int TSSFC_CMD_SLEEP_BIT = 0;
  localparam int TSSFC_CMD_WAKE_BIT = 1;
  localparam int TSSFC_CMD_PM_BIT = 2;
  localparam int TSSFC_CMD_WDCLR_BIT = 3;
  localparam int TSSFC_FAIL_FLAG_BIT = 7;
  localparam int TSSFC_WDT_PS_LSB = 1;

  // reset values
  localparam logic [3:0] TSSFC_CFG_RESET = 4'h3;
  localparam logic [1:0] TSSFC_SCS_RESET = 2'h0;
  localparam logic [4:0] TSSFC_WDT_CTRL_RESET = 5'h00;

  // timing counts
  localparam int TSSFC_SAMPLE_DIV = 64;
  localparam int TSSFC_OST_CYCLES = 1024;
  localparam int TSSFC_PLL_CYCLES = 400;
  localparam int TSSFC_WDT_DIV = 128;

  typedef enum logic [1:0] {
    TSSFC_HS = 2'h0,
    TSSFC_CRYSTAL_MULTIPLIED_MODE = 2'h1,
    TSSFC_EC = 2'h2,
    TSSFC_EXTERNAL_CLOCK_MULTIPLIED_MODE = 2'h3
  } tssfc_mode_e;

  typedef enum logic [1:0] {
    TSSFC_SRC_PRI = 2'h0,
    TSSFC_SRC_SEC = 2'h1,
    TSSFC_SRC_INT = 2'h2
  } tssfc_src_e;

  typedef enum logic [1:0] {
    TSSFC_ST_START = 2'b00,
    TSSFC_ST_RUN = 2'b01,
    TSSFC_ST_FAIL = 2'b11,
    TSSFC_ST_SLEEP = 2'b10
  } tssfc_state_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } tssfc_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } tssfc_ahb_rsp_s;

endpackage

// >>> tssfc_top.sv
// two-speed start-up sequencer, fail-safe clock monitor and watchdog with AHB-Lite registers
`timescale 1ns/10ps
module tssfc_top #(
  parameter int OST_CYCLES = tssfc_pkg::TSSFC_OST_CYCLES,
  parameter int PLL_CYCLES = tssfc_pkg::TSSFC_PLL_CYCLES,
  parameter int WDT_DIV = tssfc_pkg::TSSFC_WDT_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input tssfc_pkg::tssfc_ahb_req_s ahb_req,
  output tssfc_pkg::tssfc_ahb_rsp_s ahb_rsp,
  // oscillator levels from pins
  input wire logic primary_osc_in,
  input wire logic secondary_osc_in,
  input wire logic internal_rc_in,
  // clock control
  output logic [1:0] sys_clk_sel,
  output logic cpu_run,
  output logic internal_rc_enable,
  output logic failsafe,
  // events
  output logic oscillator_fail_flag,
  output logic wdt_timeout
);
  import tssfc_pkg::*;

  localparam int CW = 16;
  localparam logic [5:0] SAMP_HALF = 6'(TSSFC_SAMPLE_DIV / 2 - 1);
  localparam logic [5:0] SAMP_LAST = 6'(TSSFC_SAMPLE_DIV - 1);

  // pin synchronisers
  logic [2:0] pin_in;
  logic [2:0] stable_reg;
  logic [2:0] rise;
  logic [2:0] fall;
  assign pin_in = {internal_rc_in, secondary_osc_in, primary_osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic [2:0] sh_reg;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sh_reg <= 3'h0;
          stable_reg[gi] <= 1'b0;
        end else begin
          sh_reg <= {sh_reg[1:0], pin_in[gi]};
          // glitch of one sample is not an edge
          if (sh_reg[1] == sh_reg[2]) begin
            stable_reg[gi] <= sh_reg[2];
          end
        end
      end
      assign rise[gi] = (sh_reg[1] == sh_reg[2]) && sh_reg[2] && !stable_reg[gi];
      assign fall[gi] = (sh_reg[1] == sh_reg[2]) && !sh_reg[2] && stable_reg[gi];
    end
  endgenerate

  // registers
  logic [3:0] cfg_reg;
  logic [1:0] scs_reg;
  logic flag_reg;
  logic [4:0] wdt_ctrl_reg;
  logic [7:0] addr_reg;
  logic wr_reg;
  logic [31:0] rdata_reg;
  tssfc_state_e st_reg;
  tssfc_src_e src_reg;
  logic [CW-1:0] ost_reg;
  logic [CW-1:0] pll_reg;
  logic [5:0] samp_reg;
  logic seen_reg;
  logic [7:0] wdiv_reg;
  logic [15:0] wps_reg;

  logic internal_external_switchover_enable_en;
  logic fcm_en;
  tssfc_mode_e mode;
  logic crystal;
  logic addr_ok;
  logic wr_now;
  logic cmd_sleep;
  logic cmd_wake;
  logic cmd_pm;
  logic cmd_wdclr;
  logic flag_clr;
  logic pri_ready;
  logic monitor_on;
  logic mon_fall;
  logic samp_rise;
  logic samp_fall;
  logic fail_evt;
  logic wdt_en;
  logic wdt_clear;
  tssfc_src_e scs_src;
  tssfc_src_e start_src;

  assign internal_external_switchover_enable_en = cfg_reg[TSSFC_CFG_INTERNAL_EXTERNAL_SWITCHOVER_ENABLE_BIT];
  assign fcm_en = cfg_reg[TSSFC_CFG_FCM_BIT];
  assign mode = tssfc_mode_e'(cfg_reg[TSSFC_CFG_MODE_LSB +: 2]);
  assign crystal = (mode == TSSFC_HS) || (mode == TSSFC_CRYSTAL_MULTIPLIED_MODE);
  assign wdt_en = wdt_ctrl_reg[0];

  // ahb-lite slave, zero wait states
  assign addr_ok = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign wr_now = wr_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
    end else begin
      wr_reg <= addr_ok && ahb_req.hwrite;
      if (addr_ok) begin
        addr_reg <= ahb_req.haddr[7:0];
      end
    end
  end

  assign cmd_sleep = wr_now && addr_reg == TSSFC_CMD_OFS && ahb_req.hwdata[TSSFC_CMD_SLEEP_BIT];
  assign cmd_wake = wr_now && addr_reg == TSSFC_CMD_OFS && ahb_req.hwdata[TSSFC_CMD_WAKE_BIT];
  assign cmd_pm = wr_now && addr_reg == TSSFC_CMD_OFS && ahb_req.hwdata[TSSFC_CMD_PM_BIT];
  assign cmd_wdclr = wr_now && addr_reg == TSSFC_CMD_OFS && ahb_req.hwdata[TSSFC_CMD_WDCLR_BIT];
  assign flag_clr = wr_now && addr_reg == TSSFC_FLAG2_OFS
    && ahb_req.hwdata[TSSFC_FAIL_FLAG_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= TSSFC_CFG_RESET;
      scs_reg <= TSSFC_SCS_RESET;
      wdt_ctrl_reg <= TSSFC_WDT_CTRL_RESET;
    end else if (wr_now) begin
      unique case (addr_reg)
        TSSFC_CFG_OFS: cfg_reg <= ahb_req.hwdata[3:0];
        TSSFC_OSC_CTRL_OFS: scs_reg <= ahb_req.hwdata[1:0];
        TSSFC_WDT_CTRL_OFS: wdt_ctrl_reg <= ahb_req.hwdata[4:0];
        default: ;
      endcase
    end
  end

  // read data is latched in the address phase so it stands through the data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr_ok && !ahb_req.hwrite) begin
      rdata_reg <= 32'h0000_0000;
      unique case (ahb_req.haddr[7:0])
        TSSFC_CFG_OFS: rdata_reg[3:0] <= cfg_reg;
        TSSFC_OSC_CTRL_OFS: begin
          rdata_reg[1:0] <= scs_reg;
          rdata_reg[TSSFC_READY_BIT] <= (st_reg == TSSFC_ST_RUN) && (src_reg == TSSFC_SRC_PRI);
        end
        TSSFC_FLAG2_OFS: rdata_reg[TSSFC_FAIL_FLAG_BIT] <= flag_reg;
        TSSFC_STATUS_OFS: rdata_reg[5:0] <= {monitor_on, st_reg == TSSFC_ST_FAIL, src_reg, st_reg};
        TSSFC_WDT_CTRL_OFS: rdata_reg[4:0] <= wdt_ctrl_reg;
        TSSFC_WDT_COUNT_OFS: rdata_reg[15:0] <= wps_reg;
        default: ;
      endcase
    end
  end

  assign ahb_rsp.hrdata = rdata_reg;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;

  // start-up timers
  assign scs_src = scs_reg[1] ? TSSFC_SRC_INT : tssfc_src_e'(scs_reg);
  // without two-speed the crystal start waits on the primary itself, core held
  assign start_src = (crystal && !internal_external_switchover_enable_en) ? TSSFC_SRC_PRI : TSSFC_SRC_INT;
  assign pri_ready = !crystal || (ost_reg == CW'(OST_CYCLES)
    && (mode != TSSFC_CRYSTAL_MULTIPLIED_MODE || pll_reg == CW'(PLL_CYCLES)));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ost_reg <= '0;
      pll_reg <= '0;
    end else if (st_reg != TSSFC_ST_START) begin
      ost_reg <= '0;
      pll_reg <= '0;
    end else if (ost_reg != CW'(OST_CYCLES)) begin
      if (fall[0]) begin
        ost_reg <= ost_reg + CW'(1);
      end
    end else if (pll_reg != CW'(PLL_CYCLES)) begin
      pll_reg <= pll_reg + CW'(1);
    end
  end

  // clock source sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= TSSFC_ST_START;
      src_reg <= TSSFC_SRC_INT;
    end else begin
      unique case (st_reg)
        TSSFC_ST_START: begin
          if (cmd_sleep) begin
            st_reg <= TSSFC_ST_SLEEP;
          end else if (cmd_pm && scs_src != TSSFC_SRC_PRI) begin
            st_reg <= TSSFC_ST_RUN;
            src_reg <= scs_src;
          end else if (pri_ready) begin
            st_reg <= TSSFC_ST_RUN;
            src_reg <= TSSFC_SRC_PRI;
          end else begin
            src_reg <= start_src;
          end
        end
        TSSFC_ST_RUN, TSSFC_ST_FAIL: begin
          if (cmd_sleep) begin
            st_reg <= TSSFC_ST_SLEEP;
          end else if (cmd_pm) begin
            src_reg <= scs_src;
            if (scs_src == TSSFC_SRC_PRI && src_reg != TSSFC_SRC_PRI) begin
              st_reg <= TSSFC_ST_START;
            end else begin
              st_reg <= TSSFC_ST_RUN;
            end
          end else if (fail_evt) begin
            st_reg <= TSSFC_ST_FAIL;
            src_reg <= TSSFC_SRC_INT;
          end
        end
        TSSFC_ST_SLEEP: begin
          if (cmd_wake) begin
            st_reg <= TSSFC_ST_START;
            src_reg <= start_src;
          end
        end
      endcase
    end
  end

  assign sys_clk_sel = src_reg;
  assign cpu_run = (st_reg != TSSFC_ST_SLEEP) && !(st_reg == TSSFC_ST_START
    && src_reg == TSSFC_SRC_PRI);
  assign failsafe = (st_reg == TSSFC_ST_FAIL);
  assign internal_rc_enable = fcm_en || wdt_en || src_reg == TSSFC_SRC_INT;

  // sample clock from the internal rc
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samp_reg <= 6'h00;
    end else if (rise[2]) begin
      samp_reg <= samp_reg + 6'h01;
    end
  end
  assign samp_rise = rise[2] && samp_reg == SAMP_HALF;
  assign samp_fall = rise[2] && samp_reg == SAMP_LAST;

  // monitor only while an external source drives the device
  assign monitor_on = fcm_en && st_reg == TSSFC_ST_RUN && src_reg != TSSFC_SRC_INT;
  assign mon_fall = (src_reg == TSSFC_SRC_SEC) ? fall[1] : fall[0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
    end else if (!monitor_on) begin
      seen_reg <= 1'b0;
    end else if (mon_fall) begin
      seen_reg <= 1'b1;
    end else if (samp_rise) begin
      seen_reg <= 1'b0;
    end
  end

  assign fail_evt = monitor_on && samp_fall && seen_reg;

  // set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (fail_evt) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end
  assign oscillator_fail_flag = flag_reg;

  // watchdog on its own divider of the rc
  assign wdt_clear = fail_evt || cmd_sleep || cmd_wdclr;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdiv_reg <= 8'h00;
      wps_reg <= 16'h0000;
      wdt_timeout <= 1'b0;
    end else begin
      wdt_timeout <= 1'b0;
      if (wdt_clear || !wdt_en) begin
        wdiv_reg <= 8'h00;
        wps_reg <= 16'h0000;
      end else if (rise[2]) begin
        if (wdiv_reg == 8'(WDT_DIV - 1)) begin
          wdiv_reg <= 8'h00;
          if (wps_reg == 16'(16'h0001 << wdt_ctrl_reg[TSSFC_WDT_PS_LSB +: 4]) - 16'h0001) begin
            wps_reg <= 16'h0000;
            wdt_timeout <= 1'b1;
          end else begin
            wps_reg <= wps_reg + 16'h0001;
          end
        end else begin
          wdiv_reg <= wdiv_reg + 8'h01;
        end
      end
    end
  end

endmodule

// >>> tssfc_monitor.sv
// concurrent checks on the clock switching and fail-safe outputs of tssfc_top
`timescale 1ns/10ps
module tssfc_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input tssfc_pkg::tssfc_ahb_req_s ahb_req,
  input tssfc_pkg::tssfc_ahb_rsp_s ahb_rsp,
  // clock control and events
  input wire logic [1:0] sys_clk_sel,
  input wire logic cpu_run,
  input wire logic internal_rc_enable,
  input wire logic failsafe,
  input wire logic oscillator_fail_flag,
  input wire logic wdt_timeout
);
  import tssfc_pkg::*;
  logic take;
  logic cmd_dp;
  logic osc_rd_dp;
  logic exit_cmd;
  assign take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign exit_cmd = cmd_dp && (ahb_req.hwdata[0] || ahb_req.hwdata[2]);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_dp <= 1'b0;
      osc_rd_dp <= 1'b0;
    end else begin
      cmd_dp <= take && ahb_req.hwrite && ahb_req.haddr[7:0] == TSSFC_CMD_OFS;
      osc_rd_dp <= take && !ahb_req.hwrite && ahb_req.haddr[7:0] == TSSFC_OSC_CTRL_OFS;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_start: assert property ($rose(rst_n) |-> sys_clk_sel == TSSFC_SRC_INT && cpu_run)
    else $error("no internal start after reset");
  a_fail_flag: assert property ($rose(failsafe) |-> oscillator_fail_flag)
    else $error("failure without fail flag");
  a_fail_int_sel: assert property (failsafe |-> sys_clk_sel == TSSFC_SRC_INT)
    else $error("fail-safe not on internal clock");
  a_fail_rc_on: assert property (failsafe |-> internal_rc_enable)
    else $error("rc oscillator off in fail-safe");
  a_int_no_detect: assert property ($rose(failsafe) |-> $past(sys_clk_sel) != 2'h2)
    else $error("failure raised on internal clock");
  a_fail_exit: assert property ($fell(failsafe) |-> $past(exit_cmd))
    else $error("fail-safe left without command");
  a_wdt_quiet: assert property ($rose(failsafe) |=> !wdt_timeout [*8])
    else $error("watchdog not cleared on failure");
  // only judged while the state holds, so read latency does not matter
  a_ready_bit: assert property (osc_rd_dp && $stable(sys_clk_sel) && $stable(cpu_run)
    && $stable(failsafe) |-> ahb_rsp.hrdata[3] == (sys_clk_sel == 2'h0 && cpu_run && !failsafe))
    else $error("primary ready bit wrong");
  c_fail: cover property ($rose(failsafe));
  c_exit: cover property ($fell(failsafe));
  c_primary: cover property (sys_clk_sel == 2'h0 && cpu_run);
endmodule

bind tssfc_top tssfc_monitor tssfc_monitor_i (
  .clock(clock),
  .rst_n(rst_n),
  .ahb_req(ahb_req),
  .ahb_rsp(ahb_rsp),
  .sys_clk_sel(sys_clk_sel),
  .cpu_run(cpu_run),
  .internal_rc_enable(internal_rc_enable),
  .failsafe(failsafe),
  .oscillator_fail_flag(oscillator_fail_flag),
  .wdt_timeout(wdt_timeout)
);

// >>> tssfc_osc_model.sv
// oscillator pins seen by the block: crystal, secondary and internal rc
`timescale 1ns/10ps
module tssfc_osc_model #(
  parameter real PRI_HALF = 25.0,
  parameter real SEC_HALF = 35.0,
  parameter real RC_HALF = 20.0
) (
  // enables
  input wire logic pri_on,
  input wire logic sec_on,
  input wire logic rc_on,
  // oscillator levels
  output logic pri_osc,
  output logic sec_osc,
  output logic rc_osc
);
  // a stopped oscillator sits low, so no stray edge reaches the monitor
  initial begin
    pri_osc = 1'b0;
    sec_osc = 1'b0;
    rc_osc = 1'b0;
  end
  always #(PRI_HALF) pri_osc = pri_on ? !pri_osc : 1'b0;
  always #(SEC_HALF) sec_osc = sec_on ? !sec_osc : 1'b0;
  always #(RC_HALF) rc_osc = rc_on ? !rc_osc : 1'b0;
endmodule

// >>> tssfc_tb.sv
// self-checking bench for tssfc_top: register tasks and clock switching sequences
`timescale 1ns/10ps
module two_speed_startup_failsafe_clock_tb;
  import tssfc_pkg::*;
  logic clock;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] rd;
  logic pri_on, sec_on, pri_osc, sec_osc, rc_osc;
  logic [1:0] sys_clk_sel;
  logic cpu_run, rc_en, failsafe, fail_flag, wdt_timeout;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  tssfc_ahb_req_s req;
  tssfc_ahb_rsp_s rsp;
  // word transfers only, one slave so its ready is the bus ready
  assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};

  tssfc_top #(.OST_CYCLES(8), .PLL_CYCLES(4), .WDT_DIV(4)) tssfc_top_i (
    .clock(clock), .rst_n(rst_n), .ahb_req(req), .ahb_rsp(rsp),
    .primary_osc_in(pri_osc), .secondary_osc_in(sec_osc), .internal_rc_in(rc_osc),
    .sys_clk_sel(sys_clk_sel), .cpu_run(cpu_run), .internal_rc_enable(rc_en),
    .failsafe(failsafe), .oscillator_fail_flag(fail_flag), .wdt_timeout(wdt_timeout));
  tssfc_osc_model tssfc_osc_model_i (.pri_on(pri_on), .sec_on(sec_on), .rc_on(rc_en),
    .pri_osc(pri_osc), .sec_osc(sec_osc), .rc_osc(rc_osc));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int k;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    k = 0;
    do begin @(posedge clock); k++; end while (rsp.hreadyout !== 1'b1 && k < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    k = 0;
    do begin @(posedge clock); k++; end while (rsp.hreadyout !== 1'b1 && k < 100);
    rd = rsp.hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    complete_run;
  end

  initial begin
    rst_n <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    pri_on <= 1'b0;
    sec_on <= 1'b1;
    reset_dut;
    check(sys_clk_sel, TSSFC_SRC_INT);
    check(cpu_run, 1'b1);
    check(rc_en, 1'b1);
    rchk(TSSFC_CFG_OFS, 32'h3);
    rchk(8'h1C, 32'h0);
    // crystal never starts: stay internal
    repeat (200) @(posedge clock);
    check(sys_clk_sel, TSSFC_SRC_INT);
    rchk(TSSFC_OSC_CTRL_OFS, 32'h0);
    bus(TSSFC_WDT_CTRL_OFS, 1'b1, 32'h1);
    rchk(TSSFC_WDT_CTRL_OFS, 32'h1);
    // watchdog counts rc edges on its own divider
    for (n = 0; n < 400 && wdt_timeout !== 1'b1; n++) @(posedge clock);
    check(wdt_timeout, 1'b1);
    pri_on <= 1'b1;
    for (n = 0; n < 2000 && sys_clk_sel !== 2'h0; n++) @(posedge clock);
    check(cpu_run, 1'b1);
    rchk(TSSFC_OSC_CTRL_OFS, 32'h8);
    // a running clock leaves the latch set at sample fall
    for (n = 0; n < 3000 && failsafe !== 1'b1; n++) @(posedge clock);
    check(fail_flag, 1'b1);
    check(sys_clk_sel, TSSFC_SRC_INT);
    rchk(TSSFC_OSC_CTRL_OFS, 32'h0);
    rchk(TSSFC_FLAG2_OFS, 32'h80);
    bus(TSSFC_FLAG2_OFS, 1'b1, 32'h80);
    rchk(TSSFC_FLAG2_OFS, 32'h0);
    bus(TSSFC_OSC_CTRL_OFS, 1'b1, 32'h1);
    bus(TSSFC_CMD_OFS, 1'b1, 32'h4);
    @(posedge clock);
    check(failsafe, 1'b0);
    check(sys_clk_sel, TSSFC_SRC_SEC);
    for (n = 0; n < 3000 && failsafe !== 1'b1; n++) @(posedge clock);
    repeat (300) @(posedge clock);
    check(sys_clk_sel, TSSFC_SRC_INT);
    check(failsafe, 1'b1);
    pri_on <= 1'b0;
    reset_dut;
    // clock select and sleep still obeyed before the crystal is up
    bus(TSSFC_OSC_CTRL_OFS, 1'b1, 32'h1);
    bus(TSSFC_CMD_OFS, 1'b1, 32'h4);
    @(posedge clock);
    check(sys_clk_sel, TSSFC_SRC_SEC);
    bus(TSSFC_CMD_OFS, 1'b1, 32'h1);
    @(posedge clock);
    check(cpu_run, 1'b0);
    bus(TSSFC_CMD_OFS, 1'b1, 32'h2);
    @(posedge clock);
    check(sys_clk_sel, TSSFC_SRC_INT);
    // crystal mode, switchover and monitor off
    bus(TSSFC_CFG_OFS, 1'b1, 32'h0);
    // source follows the new config one edge after the write lands
    repeat (2) @(posedge clock);
    check(cpu_run, 1'b0);
    pri_on <= 1'b1;
    for (n = 0; n < 2000 && cpu_run !== 1'b1; n++) @(posedge clock);
    check(sys_clk_sel, TSSFC_SRC_PRI);
    repeat (1500) @(posedge clock);
    check(failsafe, 1'b0);
    complete_run;
  end
endmodule
